// file: logic/rpc_core.sv
`timescale 1ns/100ps
module rpc_core
  import rpc_pkg::*;
#(
  parameter int N = RPC_OUTS
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_dev_clk,
  input wire logic i_preload_en,
  input wire logic [N-1:0] i_next_state,
  input wire logic [N-1:0] i_comb_term,
  input wire logic [N-1:0] i_oe_term,
  input wire logic [N-1:0] i_cfg_comb,
  input wire logic [N-1:0] i_cfg_high,
  input wire logic [N-1:0] i_pin_in,
  output logic [N-1:0] o_pin_out,
  output logic [N-1:0] o_pin_oe,
  output logic o_preload_active
);

  if (N < 1 || N > 64)
  begin : g_chk
    $error("rpc_core: N out of range");
  end

  rpc_ctl_if c ();

  assign c.en = i_preload_en;
  assign c.dev_clk = i_dev_clk;

  rpc_preload_ctl u_ctl (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .c(c)
  );

  logic [N-1:0] state_r;
  logic [N-1:0] state_nxt;
  logic [N-1:0] out_nxt;
  logic [N-1:0] oe_nxt;
  logic act_nxt;
  logic tick;

  // Normal clocking only outside preload
  assign tick = c.rise & ~act_nxt;
  assign act_nxt = c.active | i_preload_en;

  // ------------------------------------------------------------
  // Macrocells
  // ------------------------------------------------------------
  for (genvar i = 0; i < N; i++)
  begin : g_cell
    logic level;

    always_comb
    begin
      state_nxt[i] = state_r[i];
      if (!i_cfg_comb[i])
      begin
        if (c.load)
          state_nxt[i] = i_pin_in[i];
        else if (tick)
          state_nxt[i] = i_next_state[i];
      end
      // Combinational cells bypass the register
      level = i_cfg_comb[i] ? i_comb_term[i] : state_nxt[i];
      out_nxt[i] = i_cfg_high[i] ? level : ~level;
      // Pin released so the tester can drive it
      oe_nxt[i] = i_oe_term[i] & ~act_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= {N{CLR_LEVEL}};
      o_pin_out <= {N{CLR_LEVEL}};
      o_pin_oe <= {N{OE_RESET}};
      o_preload_active <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      o_pin_out <= out_nxt;
      o_pin_oe <= oe_nxt;
      o_preload_active <= act_nxt;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_load_pin;
    c.load |=> ((state_r ^ $past(i_pin_in)) & ~$past(i_cfg_comb)) == '0;
  endproperty
  a_load_pin: assert property (p_load_pin)
    else $error("preload did not capture pin level");

  property p_hold_in_preload;
    (c.active && !c.load) |=> $stable(state_r);
  endproperty
  a_hold_in_preload: assert property (p_hold_in_preload)
    else $error("register changed during preload");

  property p_comb_untouched;
    (i_cfg_comb != '0) |=> ((state_r ^ $past(state_r)) & $past(i_cfg_comb))
      == '0;
  endproperty
  a_comb_untouched: assert property (p_comb_untouched)
    else $error("combinational cell register changed");

  property p_clear_zero;
    @(posedge i_clk) $rose(i_resetn) |-> state_r == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("registers not cleared at power-up");

  property p_clear_level;
    @(posedge i_clk) ($rose(i_resetn) && !c.rise)
      |=> ((o_pin_out ^ ~$past(i_cfg_high)) & ~$past(i_cfg_comb)) == '0;
  endproperty
  a_clear_level: assert property (p_clear_level)
    else $error("cleared output level wrong for polarity");

  property p_release_pins;
    i_preload_en |=> o_pin_oe == '0;
  endproperty
  a_release_pins: assert property (p_release_pins)
    else $error("pin driven during preload");

  // ------------------------------------------------------------
  // Checks on preload entry and exit, normal update, output levels and power-up clear
  // ------------------------------------------------------------
  property p_en_blocks_tick;
    (i_preload_en && !c.load)
      |=> $stable(state_r);
  endproperty
  a_en_blocks_tick: assert property (p_en_blocks_tick)
    else $error("register changed while enable high");

  property p_normal_update;
    tick
      |=> ((state_r ^ $past(i_next_state)) & ~$past(i_cfg_comb)) == '0;
  endproperty
  a_normal_update: assert property (p_normal_update)
    else $error("normal clock did not take next state");

  property p_load_out;
    c.load
      |=> ((o_pin_out ^ $past(i_pin_in) ^ ~$past(i_cfg_high))
        & ~$past(i_cfg_comb)) == '0;
  endproperty
  a_load_out: assert property (p_load_out)
    else $error("loaded level not shown at output");

  property p_out_polarity;
    i_resetn
      |=> ((o_pin_out ^ state_r ^ ~$past(i_cfg_high))
        & ~$past(i_cfg_comb)) == '0;
  endproperty
  a_out_polarity: assert property (p_out_polarity)
    else $error("registered output polarity wrong");

  property p_comb_follow;
    (i_cfg_comb != '0)
      |=> ((o_pin_out ^ $past(i_comb_term) ^ ~$past(i_cfg_high))
        & $past(i_cfg_comb)) == '0;
  endproperty
  a_comb_follow: assert property (p_comb_follow)
    else $error("combinational output wrong");

  property p_active_flag;
    i_preload_en
      |=> o_preload_active;
  endproperty
  a_active_flag: assert property (p_active_flag)
    else $error("preload flag low while enable high");

  property p_oe_return;
    (!i_preload_en && !c.active)
      |=> o_pin_oe == $past(i_oe_term);
  endproperty
  a_oe_return: assert property (p_oe_return)
    else $error("output enable not restored after preload");

  property p_active_drop;
    (!i_preload_en && !c.active)
      |=> !o_preload_active;
  endproperty
  a_active_drop: assert property (p_active_drop)
    else $error("preload flag stuck after exit");

  property p_clear_pins;
    @(posedge i_clk) $rose(i_resetn)
      |-> o_pin_oe == '0 && !o_preload_active;
  endproperty
  a_clear_pins: assert property (p_clear_pins)
    else $error("pins driven at power-up clear");

  c_load: cover property (c.load);
  c_enter: cover property ($rose(i_preload_en) ##[1:40] c.load);
  c_normal: cover property (tick && i_cfg_comb != '1);
  c_exit: cover property ($fell(o_preload_active));
  c_refused: cover property (i_preload_en && c.rise && !c.load);
endmodule

// file: logic/rpc_ctl_if.sv
`timescale 1ns/100ps
interface rpc_ctl_if;
  logic en;
  logic dev_clk;
  logic active;
  logic load;
  logic rise;

  modport ctl (
    input en,
    input dev_clk,
    output active,
    output load,
    output rise
  );

  modport core (
    output en,
    output dev_clk,
    input active,
    input load,
    input rise
  );
endinterface

// file: logic/rpc_pkg.sv
package rpc_pkg;
  // ------------------------------------------------------------
  // Device size and timing
  // ------------------------------------------------------------
  localparam int RPC_OUTS = 10;
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_MIN_NS = 100;
  localparam int STEP_MAX_NS = 1000;
  // Least time rounds up, longest rounds down
  localparam int SU_CYC = (STEP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_MAX_CYC = STEP_MAX_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] SU_LAST = CNT_W'(SU_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic CLR_LEVEL = 1'h0;
  localparam logic OE_RESET = 1'h0;

  // ------------------------------------------------------------
  // Preload qualifier states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RPC_IDLE  = 3'h1,
    RPC_ARMED = 3'h2,
    RPC_READY = 3'h4
  } rpc_state_t;
endpackage

// file: logic/rpc_preload_ctl.sv
`timescale 1ns/100ps
module rpc_preload_ctl
  import rpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  rpc_ctl_if.ctl c
);

  rpc_state_t state_r;
  rpc_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic dclk_r;
  logic dclk_nxt;

  // ------------------------------------------------------------
  // Setup qualifier and clock pin edge
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dclk_nxt = c.dev_clk;
    case (state_r)
      RPC_IDLE:
      begin
        cnt_nxt = CNT_ZERO;
        if (c.en)
          state_nxt = RPC_ARMED;
      end
      RPC_ARMED:
      begin
        cnt_nxt = cnt_r + CNT_ONE;
        if (!c.en)
          state_nxt = RPC_IDLE;
        else if (cnt_r == SU_LAST)
          state_nxt = RPC_READY;
      end
      RPC_READY:
      begin
        if (!c.en)
          state_nxt = RPC_IDLE;
      end
      default:
        state_nxt = RPC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= RPC_IDLE;
      cnt_r <= CNT_ZERO;
      dclk_r <= 1'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dclk_r <= dclk_nxt;
    end
  end

  assign c.rise = c.dev_clk & ~dclk_r;
  assign c.active = (state_r != RPC_IDLE);
  // Pulse only counts once elevated level has settled
  assign c.load = c.rise && (state_r == RPC_READY);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_no_early_load;
    @(posedge i_clk) disable iff (!i_resetn)
    (c.en && state_r == RPC_IDLE) |=> !c.load [*3];
  endproperty
  a_no_early_load: assert property (p_no_early_load)
    else $error("preload taken before setup time");

  property p_load_needs_en;
    @(posedge i_clk) disable iff (!i_resetn)
    c.load |-> c.en && $past(c.en);
  endproperty
  a_load_needs_en: assert property (p_load_needs_en)
    else $error("preload load without enable");
endmodule

// file: tb/rpc_test.sv
`timescale 1ns/100ps
module rpc_test
  import rpc_pkg::*;
;
  localparam int N = RPC_OUTS;
  logic i_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic dev_clk, preload_en, en_d;
  logic [N-1:0] next_state = '0, comb_term = '0, oe_term = '0;
  logic [N-1:0] cfg_comb = '0, cfg_high = '0, pin_in, v;
  logic [N-1:0] o_pin_out, o_pin_oe;
  logic o_preload_active;
  int seed = 67;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ----------------
  // Device and tester
  // ----------------
  rpc_core dut_u (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_dev_clk(dev_clk), .i_preload_en(preload_en),
    .i_next_state(next_state), .i_comb_term(comb_term),
    .i_oe_term(oe_term), .i_cfg_comb(cfg_comb),
    .i_cfg_high(cfg_high), .i_pin_in(pin_in),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
    .o_preload_active(o_preload_active));
  rpc_tester tst_u (.i_clk(i_clk), .i_pin_out(o_pin_out),
    .i_pin_oe(o_pin_oe), .o_dev_clk(dev_clk),
    .o_preload_en(preload_en), .o_pin_in(pin_in));

  initial
  begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic check(input string what, input logic [N-1:0] exp,
    input logic [N-1:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [N-1:0] exp_out(input logic [N-1:0] st);
    return ((cfg_comb & comb_term) | (~cfg_comb & st)) ^ ~cfg_high;
  endfunction

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      errors++;
      give_verdict();
    end
  end

  // Pins released and qualifier busy while enable stays high
  always @(negedge i_clk)
  begin
    if (en_d && preload_en)
    begin
      check("preload oe", '0, o_pin_oe);
      check("preload busy", N'(1), N'(o_preload_active));
    end
    en_d <= preload_en;
  end

  initial
  begin
    for (int r = 0; r < 2; r++)
    begin
      @(negedge i_clk);
      i_resetn = 1'h0;
      cfg_comb = N'($random(seed));
      cfg_high = N'($random(seed));
      repeat (4) @(negedge i_clk);
      check("reset out", '0, o_pin_out);
      i_resetn = 1'h1;
      repeat (2) @(negedge i_clk);
      check("clear out", exp_out('0), o_pin_out);
      for (int k = 0; k < 8; k++)
      begin
        next_state = N'($random(seed));
        comb_term = N'($random(seed));
        oe_term = N'($random(seed));
        v = (k == 0) ? ~next_state : N'($random(seed));
        tst_u.pulse();
        check("clock out", exp_out(next_state), o_pin_out);
        if (k == 1)
        begin
          next_state = ~next_state;
          tst_u.refused();
          check("refused out", exp_out(~next_state), o_pin_out);
        end
        tst_u.preload(v);
        check("preload out", exp_out(v), o_pin_out);
        check("after oe", oe_term, o_pin_oe);
        check("idle", '0, N'(o_preload_active));
      end
      $display("run %0d done", r);
    end
    give_verdict();
  end
endmodule

// file: tb/rpc_tester.sv
`timescale 1ns/100ps
module rpc_tester
  import rpc_pkg::*;
#(
  parameter int N = RPC_OUTS
)
(
  input wire logic i_clk,
  input wire logic [N-1:0] i_pin_out,
  input wire logic [N-1:0] i_pin_oe,
  output logic o_dev_clk,
  output logic o_preload_en,
  output logic [N-1:0] o_pin_in
);
  logic [N-1:0] drv_en = '0;
  logic [N-1:0] drv_val = '0;
  logic [N-1:0] last_r = '0;

  // ----------------
  // Pin levels
  // ----------------
  // Released pin floats: show inverse of last driven level
  always @(posedge i_clk)
    last_r <= ((i_pin_oe | drv_en) & o_pin_in) |
      (~(i_pin_oe | drv_en) & last_r);
  assign o_pin_in = (i_pin_oe & i_pin_out) |
    (~i_pin_oe & ((drv_en & drv_val) | (~drv_en & ~last_r)));

  initial
  begin
    o_dev_clk = 1'h0;
    o_preload_en = 1'h0;
  end

  task automatic wait_step();
    repeat (SU_CYC + 1) @(negedge i_clk);
  endtask

  task automatic pulse();
    o_dev_clk = 1'h1;
    wait_step();
    o_dev_clk = 1'h0;
    wait_step();
  endtask

  // Clock rise before setup elapses must be ignored
  task automatic refused();
    o_preload_en = 1'h1;
    o_dev_clk = 1'h1;
    wait_step();
    o_dev_clk = 1'h0;
    wait_step();
    o_preload_en = 1'h0;
    wait_step();
  endtask

  task automatic preload(input logic [N-1:0] val);
    o_preload_en = 1'h1;
    wait_step();
    drv_val = val;
    drv_en = '1;
    wait_step();
    pulse();
    drv_en = '0;
    wait_step();
    o_preload_en = 1'h0;
    wait_step();
  endtask
endmodule
